/* fmm_core.sv */
// Purpose: Matrix step three, 1-D/2-D min/max tracking and host-to-coprocessor moves.
// Assumes: One instruction per valid cycle; every instruction completes in one cycle.
// Notes:   Arithmetic is signed integer on the low word; high words are cleared.
`timescale 1ns/10ps

// Summary of operation
// - Step three: temp takes acc three, acc three takes partial sum, then MACs bank B two-five.
// - After step three the finished row sits in accumulators zero to three.
// - Two-dim min/max tests X and Y against their own min and max at once.
// - A value strictly below its minimum replaces it, else minimum holds.
// - A value strictly above its maximum replaces it, else maximum holds.
// - Counter steps per min/max; replaced extremes record the pre-increment count.
// - Bank B zero/one hold X min/max, bank B two/three hold Y min/max.
// - X count register: X minimum count low half, X maximum count high half.
// - Y count register: Y minimum count low half, Y maximum count high half.
// - One-dim min/max uses bank B zero/one and the X count register.
// - Y count high half changes only when Y becomes the new maximum, or on reset, init or a software write.
// - Two-dim min/max decoded by opcode and fixed nibble only; Y source field is an operand.
// - Two-value move writes destination, then the next register in sequence.
// - Double moves: word-order bit set sends low half first; resets clear.
module fmm_core
  import fmm_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              instr_valid_i,
  input  wire logic [31:0]       instr_word_i,
  input  wire logic              host_pair_i,
  input  wire logic [31:0]       host_first_i,
  input  wire logic [31:0]       host_second_i,
  input  wire logic [FMM_AW-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  output logic                   instr_done_o,
  output logic                   instr_illegal_o
);

  function automatic logic [4:0] seq_next(input logic [4:0] idx);
    seq_next = (idx == IDX_LAST) ? 5'h00 : idx + 5'h01;
  endfunction : seq_next

  function automatic logic [63:0] mac(input logic [31:0] acc, input logic [31:0] a,
                                      input logic [31:0] b);
    logic [63:0] prod;
    prod = $signed(a) * $signed(b);
    mac  = {32'h00000000, acc + prod[31:0]};
  endfunction : mac

  function automatic logic lt(input logic [31:0] a, input logic [31:0] b);
    lt = $signed(a) < $signed(b);
  endfunction : lt

  logic [FMM_RW-1:0] regf [0:FMM_NREG-1];
  logic [FMM_RW-1:0] ct;
  logic [31:0]       x_position_count;
  logic [31:0]       y_position_count;
  logic [FMM_CW-1:0] data_count;
  logic              word_order;

  // Decode
  logic [4:0] opc;
  logic [3:0] sub;
  logic [3:0] x_source_field;
  logic [3:0] y_source_field;
  logic [4:0] dest_reg_field;
  logic       is_two, is_one, is_ms3, is_init, is_move;
  logic       x_ok, y_ok, d_ok, legal;
  logic       exec_two, exec_one, exec_ms3, exec_init, exec_move, exec_mm;

  assign opc            = instr_word_i[F_OPC_HI:F_OPC_LO];
  assign sub            = instr_word_i[F_SUB_HI:F_SUB_LO];
  assign x_source_field = instr_word_i[F_XSRC_HI:F_XSRC_LO];
  assign y_source_field = instr_word_i[F_YSRC_HI:F_YSRC_LO];
  assign dest_reg_field = instr_word_i[F_DEST_HI:F_DEST_LO];

  assign is_two  = (opc == OPC_MM2) && (sub == SUB_MM2);
  assign is_one  = (opc == OPC_MM1) && (sub == SUB_EXEC) && (y_source_field == YF_ZERO);
  assign is_ms3  = (opc == OPC_MS3) && (sub == SUB_EXEC) && (y_source_field == YF_MS3);
  assign is_init = (opc == OPC_INIT) && (sub == SUB_EXEC) && (y_source_field == YF_ZERO);
  assign is_move = (instr_word_i[F_OPC_HI:F_OPC_LO+1] == MOVE_OPC_HI) && (sub == SUB_MOVE);

  // Sources outside bank A are refused rather than read from bank B
  assign x_ok  = {1'b0, x_source_field} <= IDX_BANK_A_LAST;
  assign y_ok  = {1'b0, y_source_field} <= IDX_BANK_A_LAST;
  assign d_ok  = dest_reg_field <= IDX_LAST;
  assign legal = (is_two && x_ok && y_ok) || (is_one && x_ok) || is_ms3 || is_init ||
                 (is_move && d_ok);

  assign exec_two  = instr_valid_i && is_two && x_ok && y_ok;
  assign exec_one  = instr_valid_i && is_one && x_ok;
  assign exec_ms3  = instr_valid_i && is_ms3;
  assign exec_init = instr_valid_i && is_init;
  assign exec_move = instr_valid_i && is_move && d_ok;
  assign exec_mm   = exec_two || exec_one;

  // Min/max comparisons
  logic [31:0] xv, yv, x_min, x_max, y_min, y_max;
  logic        x_min_upd, x_max_upd, y_min_upd, y_max_upd;

  assign xv    = regf[{1'b0, x_source_field}][31:0];
  assign yv    = regf[{1'b0, y_source_field}][31:0];
  assign x_min = regf[IDX_B0][31:0];
  assign x_max = regf[IDX_B1][31:0];
  assign y_min = regf[IDX_B2][31:0];
  assign y_max = regf[IDX_B3][31:0];

  assign x_min_upd = exec_mm && lt(xv, x_min);
  assign x_max_upd = exec_mm && lt(x_max, xv);
  assign y_min_upd = exec_two && lt(yv, y_min);
  assign y_max_upd = exec_two && lt(y_max, yv);

  // Host move data
  logic [4:0]  dest_next;
  logic        move_dbl;
  logic [63:0] dbl_word;

  assign dest_next = seq_next(dest_reg_field);
  assign move_dbl  = instr_word_i[F_SIZE];
  // First value is the low half only when the word-order bit is set
  assign dbl_word  = word_order ? {host_second_i, host_first_i}
                                : {host_first_i, host_second_i};

  // Software write decode
  logic sw_reg_wr;
  assign sw_reg_wr = reg_wr_i && (reg_addr_i <= A_REG_LAST) && !instr_valid_i;

  // Register file; an instruction takes priority over a software write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < FMM_NREG; i++) begin
        regf[i] <= REG_RST;
      end
    end else if (exec_ms3) begin
      regf[IDX_ACC0] <= mac(regf[IDX_ACC0][31:0], regf[IDX_ACC3][31:0], regf[IDX_B2][31:0]);
      regf[IDX_ACC1] <= mac(regf[IDX_ACC1][31:0], regf[IDX_ACC3][31:0], regf[IDX_B3][31:0]);
      regf[IDX_ACC2] <= mac(regf[IDX_ACC2][31:0], regf[IDX_ACC3][31:0], regf[IDX_B4][31:0]);
      regf[IDX_ACC3] <= mac(ct[31:0], regf[IDX_ACC3][31:0], regf[IDX_B5][31:0]);
    end else if (exec_init) begin
      regf[IDX_B0] <= {32'h00000000, MIN_PRESET};
      regf[IDX_B1] <= {32'h00000000, MAX_PRESET};
      regf[IDX_B2] <= {32'h00000000, MIN_PRESET};
      regf[IDX_B3] <= {32'h00000000, MAX_PRESET};
    end else if (exec_mm) begin
      if (x_min_upd) begin
        regf[IDX_B0] <= {32'h00000000, xv};
      end
      if (x_max_upd) begin
        regf[IDX_B1] <= {32'h00000000, xv};
      end
      if (y_min_upd) begin
        regf[IDX_B2] <= {32'h00000000, yv};
      end
      if (y_max_upd) begin
        regf[IDX_B3] <= {32'h00000000, yv};
      end
    end else if (exec_move) begin
      if (move_dbl) begin
        regf[dest_reg_field] <= dbl_word;
      end else begin
        regf[dest_reg_field] <= {32'h00000000, host_first_i};
        if (host_pair_i) begin
          regf[dest_next] <= {32'h00000000, host_second_i};
        end
      end
    end else if (sw_reg_wr) begin
      if (reg_addr_i[0]) begin
        regf[reg_addr_i[5:1]][63:32] <= reg_wdata_i;
      end else begin
        regf[reg_addr_i[5:1]][31:0] <= reg_wdata_i;
      end
    end
  end

  // Partial-sum temporary
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ct <= REG_RST;
    end else if (exec_ms3) begin
      ct <= regf[IDX_ACC3];
    end else if (reg_wr_i && !instr_valid_i && reg_addr_i == A_CT_LO) begin
      ct[31:0] <= reg_wdata_i;
    end else if (reg_wr_i && !instr_valid_i && reg_addr_i == A_CT_HI) begin
      ct[63:32] <= reg_wdata_i;
    end
  end

  // Shared data counter, free to wrap
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_count <= CNT_RST;
    end else if (exec_init) begin
      data_count <= CNT_RST;
    end else if (exec_mm) begin
      data_count <= data_count + 16'h0001;
    end else if (reg_wr_i && !instr_valid_i && reg_addr_i == A_DCOUNT) begin
      data_count <= reg_wdata_i[FMM_CW-1:0];
    end
  end

  // Position counts take the count before it steps
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || exec_init) begin
      x_position_count <= {CNT_RST, CNT_RST};
      y_position_count <= {CNT_RST, CNT_RST};
    end else if (exec_mm) begin
      if (x_min_upd) begin
        x_position_count[15:0] <= data_count;
      end
      if (x_max_upd) begin
        x_position_count[31:16] <= data_count;
      end
      if (y_min_upd) begin
        y_position_count[15:0] <= data_count;
      end
      if (y_max_upd) begin
        y_position_count[31:16] <= data_count;
      end
    end else if (reg_wr_i && !instr_valid_i && reg_addr_i == A_XCOUNT) begin
      x_position_count <= reg_wdata_i;
    end else if (reg_wr_i && !instr_valid_i && reg_addr_i == A_YCOUNT) begin
      y_position_count <= reg_wdata_i;
    end
  end

  // Configuration: word order only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      word_order <= WORD_ORDER_RST;
    end else if (reg_wr_i && !instr_valid_i && reg_addr_i == A_CONFIG) begin
      word_order <= reg_wdata_i[CFG_WORD_ORDER];
    end
  end

  // Instruction completion flags
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      instr_done_o    <= 1'b0;
      instr_illegal_o <= 1'b0;
    end else begin
      instr_done_o    <= instr_valid_i && legal;
      instr_illegal_o <= instr_valid_i && !legal;
    end
  end

  // Read port; unmapped addresses read zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_addr_i <= A_REG_LAST) begin
      next_rdata = reg_addr_i[0] ? regf[reg_addr_i[5:1]][63:32] : regf[reg_addr_i[5:1]][31:0];
    end else if (reg_addr_i == A_CT_LO) begin
      next_rdata = ct[31:0];
    end else if (reg_addr_i == A_CT_HI) begin
      next_rdata = ct[63:32];
    end else if (reg_addr_i == A_XCOUNT) begin
      next_rdata = x_position_count;
    end else if (reg_addr_i == A_YCOUNT) begin
      next_rdata = y_position_count;
    end else if (reg_addr_i == A_CONFIG) begin
      next_rdata = {31'h00000000, word_order};
    end else if (reg_addr_i == A_DCOUNT) begin
      next_rdata = {16'h0000, data_count};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence ms3_issue;
    exec_ms3;
  endsequence

  sequence ms3_row_done;
    regf[IDX_ACC3] == mac($past(ct[31:0]), $past(regf[IDX_ACC3][31:0]),
                          $past(regf[IDX_B5][31:0]));
  endsequence

  ms3_temp_a: assert property (ms3_issue |=> ct == $past(regf[IDX_ACC3]))
    else $error("step three did not copy acc three into temp");
  ms3_row_a: assert property (ms3_issue |=> ms3_row_done)
    else $error("step three acc three result wrong");
  ms3_acc0_a: assert property (ms3_issue |=> regf[IDX_ACC0] ==
      mac($past(regf[IDX_ACC0][31:0]), $past(regf[IDX_ACC3][31:0]),
          $past(regf[IDX_B2][31:0])))
    else $error("step three acc zero result wrong");
  x_min_take_a: assert property (exec_mm && lt(xv, x_min) |=>
      regf[IDX_B0][31:0] == $past(xv) && x_position_count[15:0] == $past(data_count))
    else $error("X minimum or its count not replaced");
  x_min_hold_a: assert property (exec_mm && !lt(xv, x_min) |=>
      $stable(regf[IDX_B0]) && $stable(x_position_count[15:0]))
    else $error("X minimum changed without a smaller value");
  x_max_take_a: assert property (exec_mm && lt(x_max, xv) |=>
      regf[IDX_B1][31:0] == $past(xv) && x_position_count[31:16] == $past(data_count))
    else $error("X maximum or its count not replaced");
  y_min_take_a: assert property (exec_two && lt(yv, y_min) |=>
      regf[IDX_B2][31:0] == $past(yv) && y_position_count[15:0] == $past(data_count))
    else $error("Y minimum or its count not replaced");
  y_max_count_a: assert property ($changed(y_position_count[31:16]) && !$past(exec_init) &&
      !$past(reg_wr_i) |-> $past(y_max_upd))
    else $error("Y maximum count moved without a new Y maximum");
  one_dim_y_a: assert property (exec_one |=> $stable(regf[IDX_B2]) &&
      $stable(regf[IDX_B3]) && $stable(y_position_count))
    else $error("one-dim min/max touched Y state");
  count_step_a: assert property (exec_mm |=> data_count == $past(data_count) + 16'h0001)
    else $error("data counter did not step by one");
  decode_two_a: assert property (instr_valid_i && opc == OPC_MM2 && sub == SUB_MM2 &&
      x_ok && y_ok |=> instr_done_o && !instr_illegal_o)
    else $error("two-dim min/max word not accepted");
  move_pair_a: assert property (exec_move && host_pair_i && !move_dbl |=>
      regf[$past(dest_next)][31:0] == $past(host_second_i))
    else $error("second host value not in next register");
  move_order_a: assert property (exec_move && move_dbl |=>
      regf[$past(dest_reg_field)][31:0] ==
      ($past(word_order) ? $past(host_first_i) : $past(host_second_i)))
    else $error("double move word order wrong");
  ms3_mid_acc_a: assert property (ms3_issue |=> regf[IDX_ACC1] ==
      mac($past(regf[IDX_ACC1][31:0]), $past(regf[IDX_ACC3][31:0]),
          $past(regf[IDX_B3][31:0])) && regf[IDX_ACC2] ==
      mac($past(regf[IDX_ACC2][31:0]), $past(regf[IDX_ACC3][31:0]),
          $past(regf[IDX_B4][31:0])))
    else $error("step three acc one or two result wrong");
  x_max_hold_a: assert property (exec_mm && !lt(x_max, xv) |=>
      $stable(regf[IDX_B1]) && $stable(x_position_count[31:16]))
    else $error("X maximum changed without a larger value");
  y_max_take_a: assert property (exec_two && lt(y_max, yv) |=>
      regf[IDX_B3][31:0] == $past(yv) && y_position_count[31:16] == $past(data_count))
    else $error("Y maximum or its count not replaced");
  // Refused words must leave the tracking state alone
  refuse_hold_a: assert property (instr_valid_i && !legal |=> $stable(data_count) &&
      $stable(x_position_count) && $stable(y_position_count))
    else $error("refused instruction changed tracking state");

endmodule : fmm_core

/* fmm_host_model.sv */
// Purpose: Host-side issuer of coprocessor instructions and host operand values.
// Assumes: One instruction in flight; the answer stands only in the cycle after issue.
// Notes:   Released lines show inverted values so stale data cannot pass for good.
`timescale 1ns/10ps
module fmm_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        instr_done_i,
  input  wire logic        instr_illegal_i,
  output logic             instr_valid_o,
  output logic [31:0]      instr_word_o,
  output logic             host_pair_o,
  output logic [31:0]      host_first_o,
  output logic [31:0]      host_second_o
);
  initial begin
    instr_valid_o = 1'b0;
    instr_word_o  = 32'h0;
    host_pair_o   = 1'b0;
    host_first_o  = 32'h0;
    host_second_o = 32'h0;
  end

  // Caller loads bank A sources and runs steps zero to two or init beforehand
  task automatic issue(input logic [31:0] word, input logic pair, input logic [31:0] v1,
                       input logic [31:0] v2, output logic [1:0] resp);
    @(posedge clk_sys_i);
    instr_valid_o <= 1'b1;
    instr_word_o  <= word;
    host_pair_o   <= pair;
    host_first_o  <= v1;
    host_second_o <= v2;
    @(posedge clk_sys_i);
    instr_valid_o <= 1'b0;
    instr_word_o  <= ~word;
    host_pair_o   <= ~pair;
    host_first_o  <= ~v1;
    host_second_o <= ~v2;
    #10;
    resp = {instr_illegal_i, instr_done_i};
  endtask : issue
endmodule : fmm_host_model

/* fmm_pkg.sv */
// Purpose: Constants for the min/max, matrix step three and host move datapath.
// Assumes: Integer operands in the low 32 bits of each 64-bit coprocessor register.
// Notes:   Register indices 0..9 form bank A, 10..19 form bank B.
package fmm_pkg;
  localparam int          FMM_DW       = 32;
  localparam int          FMM_RW       = 64;
  localparam int          FMM_NREG     = 20;
  localparam int          FMM_CW       = 16;
  localparam int          FMM_AW       = 6;
  // Register indices in the sequence list
  localparam logic [4:0]  IDX_BANK_A_LAST = 5'h09;
  localparam logic [4:0]  IDX_B0       = 5'h0a;
  localparam logic [4:0]  IDX_B1       = 5'h0b;
  localparam logic [4:0]  IDX_B2       = 5'h0c;
  localparam logic [4:0]  IDX_B3       = 5'h0d;
  localparam logic [4:0]  IDX_B4       = 5'h0e;
  localparam logic [4:0]  IDX_B5       = 5'h0f;
  localparam logic [4:0]  IDX_ACC0     = 5'h10;
  localparam logic [4:0]  IDX_ACC1     = 5'h11;
  localparam logic [4:0]  IDX_ACC2     = 5'h12;
  localparam logic [4:0]  IDX_ACC3     = 5'h13;
  localparam logic [4:0]  IDX_LAST     = 5'h13;
  // Instruction word fields
  localparam int          F_XSRC_HI    = 28;
  localparam int          F_XSRC_LO    = 25;
  localparam int          F_OPC_HI     = 24;
  localparam int          F_OPC_LO     = 20;
  localparam int          F_YSRC_HI    = 19;
  localparam int          F_YSRC_LO    = 16;
  localparam int          F_SUB_HI     = 15;
  localparam int          F_SUB_LO     = 12;
  localparam int          F_DEST_HI    = 20;
  localparam int          F_DEST_LO    = 16;
  localparam int          F_SIZE       = 7;
  // Instruction codes
  localparam logic [4:0]  OPC_MM2      = 5'h06;
  localparam logic [3:0]  SUB_MM2      = 4'hb;
  localparam logic [4:0]  OPC_MM1      = 5'h04;
  localparam logic [3:0]  SUB_EXEC     = 4'h3;
  localparam logic [3:0]  YF_ZERO      = 4'h0;
  localparam logic [4:0]  OPC_MS3      = 5'h00;
  localparam logic [3:0]  YF_MS3       = 4'he;
  localparam logic [4:0]  OPC_INIT     = 5'h05;
  localparam logic [3:0]  MOVE_OPC_HI  = 4'h0;
  localparam logic [3:0]  SUB_MOVE     = 4'h4;
  // Software register map, word addresses
  localparam logic [5:0]  A_REG_LAST   = 6'h27;
  localparam logic [5:0]  A_CT_LO      = 6'h28;
  localparam logic [5:0]  A_CT_HI      = 6'h29;
  localparam logic [5:0]  A_XCOUNT     = 6'h2a;
  localparam logic [5:0]  A_YCOUNT     = 6'h2b;
  localparam logic [5:0]  A_CONFIG     = 6'h2c;
  localparam logic [5:0]  A_DCOUNT     = 6'h2d;
  localparam int          CFG_WORD_ORDER = 0;
  // Reset and preset values
  localparam logic        WORD_ORDER_RST = 1'b0;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [31:0] MIN_PRESET   = 32'h7fffffff;
  localparam logic [31:0] MAX_PRESET   = 32'h80000000;
  localparam logic [63:0] REG_RST      = 64'h0000000000000000;
endpackage : fmm_pkg

/* tb_fpu_minmax_matrix_move.sv */
// Purpose: Self-checking bench for min/max tracking, matrix step three and host moves.
// Assumes: Register port answers one cycle after a read strobe.
// Notes:   Expected values are worked out by hand from signed integer arithmetic.
`timescale 1ns/10ps
module tb_fpu_minmax_matrix_move;
  import fmm_pkg::*;
  logic              clk_sys_i;
  logic              rst_i;
  logic              instr_valid_i;
  logic [31:0]       instr_word_i;
  logic              host_pair_i;
  logic [31:0]       host_first_i;
  logic [31:0]       host_second_i;
  logic [FMM_AW-1:0] reg_addr_i;
  logic [31:0]       reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [31:0]       reg_rdata_o;
  logic              instr_done_o;
  logic              instr_illegal_o;
  int                err_total;
  int                checks_done;

  fmm_core fmm_core_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .host_pair_i(host_pair_i), .host_first_i(host_first_i),
    .host_second_i(host_second_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .instr_done_o(instr_done_o), .instr_illegal_o(instr_illegal_o));
  fmm_host_model fmm_host_model_i (.clk_sys_i(clk_sys_i), .instr_done_i(instr_done_o),
    .instr_illegal_i(instr_illegal_o), .instr_valid_o(instr_valid_i),
    .instr_word_o(instr_word_i), .host_pair_o(host_pair_i), .host_first_o(host_first_i),
    .host_second_o(host_second_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] mk(input logic [3:0] x, input logic [4:0] op,
                                     input logic [3:0] y, input logic [3:0] sub);
    return {3'h0, x, op, y, sub, 12'h000};
  endfunction : mk

  function automatic logic [31:0] mv(input logic [4:0] dest, input logic dbl);
    return {11'h000, dest, SUB_MOVE, 4'h0, dbl, 7'h00};
  endfunction : mv

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #10;
    chk(reg_rdata_o, exp);
  endtask : rdchk

  task automatic run(input logic [31:0] w, input logic p, input logic [31:0] v1,
                     input logic [31:0] v2, input logic [1:0] exp);
    logic [1:0] resp;
    fmm_host_model_i.issue(w, p, v1, v2, resp);
    chk({30'h0, resp}, {30'h0, exp});
  endtask : run

  task automatic t_reset;
    rdchk(A_XCOUNT, 32'h0);
    rdchk(A_YCOUNT, 32'h0);
    rdchk(A_CONFIG, 32'h0);
    rdchk(A_DCOUNT, 32'h0);
    wr(6'h2e, 32'h5a5a5a5a);
    rdchk(6'h2e, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_two_dim;
    logic [31:0] xs [4] = '{32'h5, 32'h5, 32'hfffffff9, 32'h9};
    logic [31:0] ys [4] = '{32'hfffffffd, 32'ha, 32'ha, 32'hfffffff8};
    run(mk(4'h0, OPC_INIT, YF_ZERO, SUB_EXEC), 1'b0, 32'h0, 32'h0, 2'b01);
    // Ties at steps one and two must leave the earlier extremes alone
    for (int i = 0; i < 4; i++) begin
      wr(6'h02, xs[i]);
      wr(6'h08, ys[i]);
      run(mk(4'h1, OPC_MM2, 4'h4, SUB_MM2), 1'b0, 32'h0, 32'h0, 2'b01);
    end
    rdchk(6'h14, 32'hfffffff9);
    rdchk(6'h16, 32'h9);
    rdchk(6'h18, 32'hfffffff8);
    rdchk(6'h1a, 32'ha);
    rdchk(A_XCOUNT, 32'h00030002);
    rdchk(A_YCOUNT, 32'h00010003);
    rdchk(A_DCOUNT, 32'h4);
    $display("two-dim test done");
  endtask : t_two_dim

  task automatic t_one_dim;
    run(mk(4'h0, OPC_INIT, YF_ZERO, SUB_EXEC), 1'b0, 32'h0, 32'h0, 2'b01);
    wr(A_DCOUNT, 32'h0000ffff);
    wr(6'h06, 32'h4);
    run(mk(4'h3, OPC_MM1, YF_ZERO, SUB_EXEC), 1'b0, 32'h0, 32'h0, 2'b01);
    wr(6'h06, 32'h2);
    run(mk(4'h3, OPC_MM1, YF_ZERO, SUB_EXEC), 1'b0, 32'h0, 32'h0, 2'b01);
    rdchk(6'h14, 32'h2);
    rdchk(6'h16, 32'h4);
    rdchk(A_XCOUNT, 32'hffff0000);
    rdchk(A_YCOUNT, 32'h0);
    rdchk(A_DCOUNT, 32'h1);
    $display("one-dim test done");
  endtask : t_one_dim

  task automatic t_step3;
    logic [31:0] v [10] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'ha, 32'h14, 32'h1e,
                            32'h28, 32'h0};
    logic [5:0]  a [9]  = '{6'h20, 6'h22, 6'h24, 6'h26, A_CT_LO, 6'h18, 6'h1a, 6'h1c, 6'h1e};
    for (int i = 0; i < 9; i++) begin
      wr(a[i], v[i]);
    end
    run(mk(4'h0, OPC_MS3, YF_MS3, SUB_EXEC), 1'b0, 32'h0, 32'h0, 2'b01);
    rdchk(6'h20, 32'h1 + 32'h4 * 32'ha);
    rdchk(6'h22, 32'h2 + 32'h4 * 32'h14);
    rdchk(6'h24, 32'h3 + 32'h4 * 32'h1e);
    rdchk(6'h26, 32'h5 + 32'h4 * 32'h28);
    rdchk(6'h27, 32'h0);
    rdchk(A_CT_LO, 32'h4);
    $display("matrix step three test done");
  endtask : t_step3

  task automatic t_moves;
    run(mv(5'h13, 1'b0), 1'b1, 32'h11111111, 32'h22222222, 2'b01);
    rdchk(6'h26, 32'h11111111);
    rdchk(6'h00, 32'h22222222);
    // Without a second value the next register must keep its old contents
    run(mv(5'h02, 1'b0), 1'b0, 32'h55555555, 32'h66666666, 2'b01);
    rdchk(6'h04, 32'h55555555);
    rdchk(6'h06, 32'h00000002);
    run(mv(5'h05, 1'b1), 1'b1, 32'haaaaaaaa, 32'hbbbbbbbb, 2'b01);
    rdchk(6'h0b, 32'haaaaaaaa);
    rdchk(6'h0a, 32'hbbbbbbbb);
    wr(A_CONFIG, 32'h1);
    rdchk(A_CONFIG, 32'h1);
    run(mv(5'h06, 1'b1), 1'b1, 32'hcccccccc, 32'hdddddddd, 2'b01);
    rdchk(6'h0c, 32'hcccccccc);
    rdchk(6'h0d, 32'hdddddddd);
    $display("move test done");
  endtask : t_moves

  task automatic t_illegal;
    run(mv(5'h14, 1'b0), 1'b1, 32'h33333333, 32'h44444444, 2'b10);
    run(mk(4'ha, OPC_MM2, 4'h1, SUB_MM2), 1'b0, 32'h0, 32'h0, 2'b10);
    run(mk(4'h1, OPC_MM2, 4'h4, 4'ha), 1'b0, 32'h0, 32'h0, 2'b10);
    rdchk(A_DCOUNT, 32'h1);
    rdchk(6'h00, 32'h22222222);
    $display("refusal test done");
  endtask : t_illegal

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    err_total   = 0;
    checks_done = 0;
    rst_i       = 1'b1;
    reg_addr_i  = '0;
    reg_wdata_i = 32'h0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset;
    t_two_dim;
    t_one_dim;
    t_step3;
    t_moves;
    t_illegal;
    report_and_stop;
  end

  // Hang guard well beyond the longest sequence
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    report_and_stop;
  end
endmodule : tb_fpu_minmax_matrix_move
